// ### core/iplr_apb_slave.sv
// APB slave front end: decodes a word index, makes the write strobe, word select and error
module iplr_apb_slave
  import iplr_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [IPLR_ADDR_W-1:0] paddr,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        wr_en,
  output logic [1:0]                  reg_sel,
  output logic                        hit
);

  logic [IPLR_ADDR_W-3:0] word_idx;

  // Zero wait states; one access phase per transfer
  assign pready   = 1'b1;
  assign word_idx = paddr[IPLR_ADDR_W-1:2];

  // Address decode; low address bits must be zero for an aligned word
  always_comb
  begin
    hit     = 1'b1;
    reg_sel = 2'd0;
    if (paddr[1:0] != 2'b00)
      hit = 1'b0;
    else if (word_idx == {6'h00, IPLR_IDX_SIX})
      reg_sel = 2'd0;
    else if (word_idx == {6'h00, IPLR_IDX_SEVEN})
      reg_sel = 2'd1;
    else if (word_idx == {6'h00, IPLR_IDX_EIGHT})
      reg_sel = 2'd2;
    else if (word_idx == {6'h00, IPLR_IDX_NINE})
      reg_sel = 2'd3;
    else
      hit = 1'b0;
  end

  // Error only in the access phase, so the master sees it with pready
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;

endmodule

// ### core/iplr_bank.sv
// Interrupt priority-level register bank with request gating and APB access
//
// Functional notes
// - Two-bit field: 00 off, else level 0-2
// - Only levels 0 through 2 ever offered
// - All fields reset to disabled
// - Reserved bit pairs read zero, ignore writes
// - Word six bits 7-6: timer D ch0
// - Word six bits 3-2: decoder 0 index
// - Word six bits 1-0: decoder 0 home/watchdog
// - Word seven high: timer A0, B3, B2, B1
// - Word seven low: timer B0, C3, C2, C1
// - Word eight high: serial rx full, rx error, tx idle
// - Word eight low: serial tx empty, A3-A1
// - Word nine bits 15-14: PWM A fault
module iplr_bank
  import iplr_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [iplr_pkg::IPLR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [18:0]                 src_req,
  output logic      [18:0]                 prio_req,
  output logic      [37:0]                 prio_level
);
  import iplr_pkg::*;

  localparam int NSRC = 19;

  // Field location of each source: word select and low bit
  localparam logic [1:0] SRC_WORD [NSRC] = '{
    2'd0, 2'd0, 2'd0,
    2'd1, 2'd1, 2'd1, 2'd1, 2'd1, 2'd1, 2'd1, 2'd1,
    2'd2, 2'd2, 2'd2, 2'd2, 2'd2, 2'd2, 2'd2,
    2'd3};
  localparam logic [3:0] SRC_LSB [NSRC] = '{
    4'd6, 4'd2, 4'd0,
    4'd14, 4'd12, 4'd10, 4'd8, 4'd6, 4'd4, 4'd2, 4'd0,
    4'd14, 4'd12, 4'd8, 4'd6, 4'd4, 4'd2, 4'd0,
    4'd14};

  logic                  wr_en;
  logic                  hit;
  logic [1:0]            reg_sel;
  logic [IPLR_REG_W-1:0] prio_word [IPLR_NUM_REGS];
  logic [IPLR_REG_W-1:0] wr_mask   [IPLR_NUM_REGS];

  // Bus front end
  iplr_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_en   (wr_en),
    .reg_sel (reg_sel),
    .hit     (hit)
  );

  // Writable masks per word; reserved bits never stored
  assign wr_mask[0] = IPLR_MASK_SIX;
  assign wr_mask[1] = IPLR_MASK_SEVEN;
  assign wr_mask[2] = IPLR_MASK_EIGHT;
  assign wr_mask[3] = IPLR_MASK_NINE;

  // Priority words; updated at the completing access edge only
  generate
    for (genvar w = 0; w < IPLR_NUM_REGS; w++)
    begin : g_word
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          prio_word[w] <= IPLR_RESET_VAL;
        else if (wr_en && reg_sel == 2'(w))
          prio_word[w] <= pwdata[IPLR_REG_W-1:0] & wr_mask[w];
      end
    end
  endgenerate

  // Read data registered from the setup phase so it is stable in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (hit)
        prdata <= {16'h0000, prio_word[reg_sel]};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // One gate per source; a late write takes effect on the next cycle
  generate
    for (genvar s = 0; s < NSRC; s++)
    begin : g_src
      iplr_gate u_gate (
        .field   (prio_word[SRC_WORD[s]][SRC_LSB[s] +: 2]),
        .req_in  (src_req[s]),
        .req_out (prio_req[s]),
        .level   (prio_level[2*s +: 2])
      );
    end
  endgenerate

endmodule

// ### core/iplr_gate.sv
// Per-source request gate: suppresses disabled sources, tags level
module iplr_gate
  import iplr_pkg::*;
(
  input  wire logic [1:0] field,
  input  wire logic       req_in,
  output logic            req_out,
  output logic [1:0]      level
);

  // Level is field minus one; only 0..2 reachable, no encoding gives 3
  always_comb
  begin
    req_out = 1'b0;
    level   = 2'd0;
    case (field)
      IPLR_FLD_L0:
      begin
        req_out = req_in;
        level   = 2'd0;
      end
      IPLR_FLD_L1:
      begin
        req_out = req_in;
        level   = 2'd1;
      end
      IPLR_FLD_L2:
      begin
        req_out = req_in;
        level   = 2'd2;
      end
      default:
      begin
        req_out = 1'b0;
        level   = 2'd0;
      end
    endcase
  end

endmodule

// ### core/iplr_pkg.sv
// Package: register map, field layout and encodings of the priority-level bank
package iplr_pkg;

  // Printed register indices (word indices, not byte offsets, so byte address = 4 * index)
  localparam logic [3:0] IPLR_IDX_SIX   = 4'h6;
  localparam logic [3:0] IPLR_IDX_SEVEN = 4'h7;
  localparam logic [3:0] IPLR_IDX_EIGHT = 4'h8;
  localparam logic [3:0] IPLR_IDX_NINE  = 4'h9;
  localparam int         IPLR_ADDR_W    = 12;
  localparam int         IPLR_REG_W     = 16;
  localparam int         IPLR_NUM_REGS  = 4;
  localparam int         IPLR_NUM_SRC   = 23;

  // Reset value of every priority word: all fields disabled
  localparam logic [15:0] IPLR_RESET_VAL = 16'h0000;

  // Writable-bit masks; reserved pairs stay zero
  localparam logic [15:0] IPLR_MASK_SIX   = 16'h00cf;
  localparam logic [15:0] IPLR_MASK_SEVEN = 16'hffff;
  localparam logic [15:0] IPLR_MASK_EIGHT = 16'hf3ff;
  localparam logic [15:0] IPLR_MASK_NINE  = 16'hc000;

  // Field encodings
  typedef enum logic [1:0] {
    IPLR_FLD_OFF = 2'b00,
    IPLR_FLD_L0  = 2'b01,
    IPLR_FLD_L1  = 2'b10,
    IPLR_FLD_L2  = 2'b11
  } iplr_field_t;

  // Source order on the request vectors; bit index on the vectors per entry
  localparam int IPLR_SRC_TMRD0  = 0;
  localparam int IPLR_SRC_DEC0X  = 1;
  localparam int IPLR_SRC_DEC0H  = 2;
  localparam int IPLR_SRC_TMRA0  = 3;
  localparam int IPLR_SRC_TMRB3  = 4;
  localparam int IPLR_SRC_TMRB2  = 5;
  localparam int IPLR_SRC_TMRB1  = 6;
  localparam int IPLR_SRC_TMRB0  = 7;
  localparam int IPLR_SRC_TMRC3  = 8;
  localparam int IPLR_SRC_TMRC2  = 9;
  localparam int IPLR_SRC_TMRC1  = 10;
  localparam int IPLR_SRC_SRXF   = 11;
  localparam int IPLR_SRC_SRXE   = 12;
  localparam int IPLR_SRC_STXI   = 13;
  localparam int IPLR_SRC_STXE   = 14;
  localparam int IPLR_SRC_TMRA3  = 15;
  localparam int IPLR_SRC_TMRA2  = 16;
  localparam int IPLR_SRC_TMRA1  = 17;
  localparam int IPLR_SRC_PWMAF  = 18;

endpackage

// ### dv/iplr_bank_monitor.sv
// Checker of the priority bank port behaviour
module iplr_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [18:0] src_req,
  input wire logic [18:0] prio_req,
  input wire logic [37:0] prio_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic top3;
  // Write taken at this edge
  assign wr = psel && penable && pwrite;
  // Any source tagged with the missing fourth level
  always_comb
  begin
    top3 = 1'b0;
    for (int s = 0; s < 19; s++)
      top3 = top3 | (prio_level[2*s+:2] == 2'b11);
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  level_cap_a: assert property (!top3)
    else $error("level 3 offered");
  gate_src_a: assert property ((prio_req & ~src_req) == 19'h0)
    else $error("stray request");
  reset_off_a: assert property ($rose(presetn) |-> prio_req == 19'h0)
    else $error("request after reset");
  tmr_d0_a: assert property (wr && paddr == 12'h018 && pwdata[7:6] != 2'b00 |=>
    prio_req[0] == src_req[0] && prio_level[1:0] == $past(pwdata[7:6]) - 2'd1)
    else $error("timer d0 field");
  tmr_a0_a: assert property (wr && paddr == 12'h01c && pwdata[15:14] != 2'b00 |=>
    prio_req[3] == src_req[3] && prio_level[7:6] == $past(pwdata[15:14]) - 2'd1)
    else $error("timer a0 field");
  pwm_off_a: assert property (wr && paddr == 12'h024 && pwdata[15:14] == 2'b00 |=>
    !prio_req[18] [*2])
    else $error("fault not suppressed");
  bad_addr_a: assert property (psel && penable && paddr == 12'h040 |-> pslverr)
    else $error("no error on hole");
  rsvd_read_a: assert property (psel && penable && !pwrite && paddr == 12'h020 |->
    prdata[11:10] == 2'b00 && prdata[31:16] == 16'h0)
    else $error("reserved bits set");
  cover property (wr && paddr == 12'h024);
  cover property (psel && penable && pslverr);
  cover property (prio_req[18] && prio_level[37:36] == 2'd2);
endmodule

bind iplr_bank iplr_monitor chk (.*);

// ### dv/iplr_bank_tb.sv
// Testbench: register access and request gating of the priority bank
module iplr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iplr_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, v, r;
  logic        pready, pslverr;
  logic [18:0] src_req = 19'h0, prio_req;
  logic [37:0] prio_level;
  logic [1:0]  top_level;
  logic [31:0] exp_q[$];
  logic [15:0] last[4];
  int          miscompares = 0, checked = 0, seed = 63;
  logic [11:0] addr[4] = '{12'h018, 12'h01c, 12'h020, 12'h024};
  logic [15:0] mask[4] = '{IPLR_MASK_SIX, IPLR_MASK_SEVEN, IPLR_MASK_EIGHT, IPLR_MASK_NINE};
  iplr_bank dut (.*);
  iplr_core_model core (.pclk(pclk), .prio_req(prio_req), .prio_level(prio_level),
    .top_level(top_level));
  initial forever #10 pclk = ~pclk;
  // Sources toggle at random every cycle
  always @(posedge pclk) src_req <= 19'($random(seed));
  task automatic wrap_up;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; d is write data, or the read value expected
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    if (!w) exp_q.push_back(d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  // Watcher: each completed read takes the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      v = exp_q.pop_front();
      checked++;
      if (prdata !== v)
      begin
        miscompares++;
        $display("unexpected prdata at %h: expected %h seen %h", paddr, v, prdata);
      end
    end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) apb(1'b0, addr[i], 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    for (int k = 0; k < 12; k++)
    begin
      r = $random(seed);
      last[k%4] = r[15:0] & mask[k%4];
      apb(1'b1, addr[k%4], r);
      apb(1'b0, addr[k%4], {16'h0, last[k%4]});
    end
    apb(1'b1, 12'h01e, 32'hffff);
    apb(1'b0, addr[1], {16'h0, last[1]});
    for (int e = 0; e < 4; e++)
    begin
      apb(1'b1, addr[3], {16'h0, e[1:0], 14'h0});
      @(negedge pclk);
      checked++;
      if (prio_req[18] !== (src_req[18] && e != 0)
          || prio_level[37:36] !== (e != 0 ? e[1:0] - 2'd1 : 2'd0))
      begin
        miscompares++;
        $display("unexpected fault level: expected %0d seen %h", (e != 0 ? e - 1 : 0),
                 prio_level[37:36]);
      end
    end
    // Mid-run reset is launched on a rising edge like every other stimulus
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) apb(1'b0, addr[i], 32'h0);
    wrap_up();
  end
endmodule

// ### dv/iplr_core_model.sv
// Core-side sink: latches the highest level on offer
module iplr_core_model
(
  input  wire logic        pclk,
  input  wire logic [18:0] prio_req,
  input  wire logic [37:0] prio_level,
  output logic      [1:0]  top_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hi;
  // Pick the top live level; arbitration among equals is not modelled
  always @(posedge pclk)
  begin
    hi = 2'h0;
    for (int s = 0; s < 19; s++)
      if (prio_req[s] && prio_level[2*s+:2] > hi) hi = prio_level[2*s+:2];
    top_level <= hi;
  end
endmodule
